// >>> core/pcv_top.sv
// port configuration, virtual port windows and clock/event pin routing
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
// Operation
// RULE_01: mask bits pick pins for group write
// RULE_02: per-pin write copies to all masked pins
// RULE_03: addressed pin need not be masked
// RULE_04: mask clears after any per-pin write
// RULE_05: map A selects ports for vports 1,0
// RULE_06: map B selects ports for vports 3,2
// RULE_07: selector value is physical port number
// RULE_08: vport accesses equal physical register accesses
// RULE_09: vport input reads synchronised pin levels
// RULE_10: flag sets on sensed pin change
// RULE_11: write one clears flag, zero keeps
// RULE_12: flag bits 7:2 read zero
// RULE_13: routing bits 7:6 read one
// RULE_14: event field routes channel 0 to pin 7
// RULE_15: event shown only on output pin
// RULE_16: clock choice 1x, 2x or 4x
// RULE_17: clock field routes clock to pin 7
// RULE_18: clock wins over event on same pin
// RULE_19: clock shown only on output pin
// RULE_20: software keeps clock and event ports apart
// RULE_21: sense field: both, rise, fall, low
// RULE_22: direction one means output
// RULE_23: broadcast and mask clear in one write
module pcv_top
	import pcv_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [AW-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// pins and event channel
	input wire logic [NP-1:0][7:0] pin_in,
	input wire logic event_ch0,
	output logic [NP-1:0][7:0] pin_out,
	output logic [NP-1:0][7:0] pin_oe_n,
	output logic [NP-1:0] pin7_clk_sel,
	output logic [1:0] output_clock_choice
);

	pcv_state_s r;
	pcv_state_s n;
	pcv_dec_s w_dec;
	pcv_dec_s r_dec;
	logic w_go;
	logic [3:0] w_port;
	logic [2:0] w_pin;

	// address decode; virtual windows fold onto the mapped physical port
	function automatic pcv_dec_s decode(input logic [AW-1:0] a, input logic [3:0][3:0] vm);
		pcv_dec_s d;
		d = '0;
		if (a[1:0] != 2'h0)
			d = '0;
		else if (a[11])
		begin
			d.phy = 1'b1;
			d.port = a[10:7];
			d.idx = a[6:2];
		end
		else if (a[11:8] == VP_BASE[11:8] && a[7:6] == 2'h0)
		begin
			d.phy = 1'b1;
			d.port = vm[a[5:4]]; // RULE_05 RULE_06 RULE_07
			case (a[3:2]) // RULE_08
				VP_DIR: d.idx = PHY_DIR;
				VP_OUT: d.idx = PHY_OUT;
				VP_IN: d.idx = PHY_IN;
				VP_FLAGS: d.idx = PHY_FLAGS;
				default: d.idx = PHY_DIR;
			endcase
		end
		else if (a[11:5] == CFG_BASE[11:5])
		begin
			d.cfg = 1'b1;
			d.idx = {2'h0, a[4:2]};
		end
		return d;
	endfunction : decode

	// read value of a decoded register, unmapped reads zero
	function automatic logic [7:0] rd_byte(input pcv_dec_s d, input pcv_state_s s);
		logic [7:0] v;
		v = 8'h00;
		if (d.cfg)
		begin
			case (d.idx)
				CFG_MASK: v = s.mask;
				CFG_VPA: v = {s.vpmap[1], s.vpmap[0]};
				CFG_VPB: v = {s.vpmap[3], s.vpmap[2]};
				CFG_CLKEV: v = {CLKEV_RSVD, s.event_output_port, s.clksel, s.clock_output_port}; // RULE_13
				default: v = 8'h00;
			endcase
		end
		else if (d.phy)
		begin
			case (d.idx)
				PHY_DIR, PHY_DIRSET, PHY_DIRCLR, PHY_DIRTGL: v = s.dir[d.port];
				PHY_OUT, PHY_OUTSET, PHY_OUTCLR, PHY_OUTTGL: v = s.out[d.port];
				PHY_IN: v = s.lvl[d.port]; // RULE_09
				PHY_IM0: v = s.im0[d.port];
				PHY_IM1: v = s.im1[d.port];
				PHY_FLAGS: v = {FLAGS_RSVD, s.flags[d.port]}; // RULE_12
				default:
				begin
					if (d.idx[4:3] == PHY_PCTL_HI)
						v = {1'b0, s.pctl[d.port][d.idx[2:0]][6:0]};
					else
						v = 8'h00;
				end
			endcase
		end
		return v;
	endfunction : rd_byte

	// write-side and read-side helpers shared by the update logic and the checks
	assign w_go = r.ap_valid & r.ap_write;
	assign w_dec = decode(r.ap_addr, r.vpmap);
	assign r_dec = decode(r.ap_addr, r.vpmap);
	assign w_port = w_dec.port;
	assign w_pin = w_dec.idx[2:0];

	// next-state logic
	always_comb
	begin
		logic [7:0] d;
		logic [NP-1:0][1:0] fclr;
		logic [NP-1:0][1:0] fset;
		logic [2:0] input_sense_field;
		logic lv;
		logic trig;
		d = hwdata[7:0];
		fclr = '0;
		fset = '0;
		input_sense_field = 3'h0;
		lv = 1'b0;
		trig = 1'b0;
		n = r;

		// three-stage pin synchroniser, level taken once stages two and three agree
		n.sy1 = pin_in;
		n.sy2 = r.sy1;
		n.sy3 = r.sy2;
		for (int p = 0; p < NP; p++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				if (r.sy2[p][b] == r.sy3[p][b])
					n.filt[p][b] = r.sy3[p][b];
				input_sense_field = r.pctl[p][b][2:0];
				lv = (input_sense_field == ISC_OFF) ? 1'b0 : (r.filt[p][b] ^ r.pctl[p][b][PCTL_INV]); // RULE_09
				n.lvl[p][b] = lv;
				case (input_sense_field) // RULE_21
					ISC_BOTH: trig = lv != r.lvl[p][b];
					ISC_RISE: trig = lv & ~r.lvl[p][b];
					ISC_FALL: trig = ~lv & r.lvl[p][b];
					ISC_LOW: trig = ~lv;
					default: trig = 1'b0;
				endcase
				fset[p][0] = fset[p][0] | (trig & r.im0[p][b]); // RULE_10
				fset[p][1] = fset[p][1] | (trig & r.im1[p][b]); // RULE_10
			end
		end

		// bus address phase; reads get one wait state so preceding writes land first
		n.ap_valid = hsel & hready & htrans[1];
		if (hsel & hready & htrans[1])
		begin
			n.ap_addr = haddr;
			n.ap_write = hwrite;
		end
		n.hready = ~(hsel & hready & htrans[1] & ~hwrite);
		if (!r.hready)
			n.hrdata = {24'h000000, rd_byte(r_dec, r)};

		// bus write data phase
		if (w_go && w_dec.cfg)
		begin
			case (w_dec.idx)
				CFG_MASK: n.mask = d; // RULE_01
				CFG_VPA: n.vpmap[1:0] = {d[7:4], d[3:0]}; // RULE_05
				CFG_VPB: n.vpmap[3:2] = {d[7:4], d[3:0]}; // RULE_06
				CFG_CLKEV: {n.event_output_port, n.clksel, n.clock_output_port} = d[5:0];
				default: n.mask = r.mask;
			endcase
		end
		else if (w_go && w_dec.phy)
		begin
			case (w_dec.idx) // RULE_08
				PHY_DIR: n.dir[w_port] = d;
				PHY_DIRSET: n.dir[w_port] = r.dir[w_port] | d;
				PHY_DIRCLR: n.dir[w_port] = r.dir[w_port] & ~d;
				PHY_DIRTGL: n.dir[w_port] = r.dir[w_port] ^ d;
				PHY_OUT: n.out[w_port] = d;
				PHY_OUTSET: n.out[w_port] = r.out[w_port] | d;
				PHY_OUTCLR: n.out[w_port] = r.out[w_port] & ~d;
				PHY_OUTTGL: n.out[w_port] = r.out[w_port] ^ d;
				PHY_IM0: n.im0[w_port] = d;
				PHY_IM1: n.im1[w_port] = d;
				PHY_FLAGS: fclr[w_port] = d[1:0]; // RULE_11
				default:
				begin
					if (w_dec.idx[4:3] == PHY_PCTL_HI)
					begin
						for (int b = 0; b < 8; b++)
						begin
							if (b == int'(w_pin) || r.mask[b]) // RULE_02 RULE_03 RULE_23
								n.pctl[w_port][b] = {1'b0, d[6:0]};
						end
						n.mask = 8'h00; // RULE_04 RULE_23
					end
				end
			endcase
		end

		// flags: a set in the clearing cycle wins
		for (int p = 0; p < NP; p++)
			n.flags[p] = (r.flags[p] & ~fclr[p]) | fset[p]; // RULE_11

		// pin drivers with clock and event routing onto pin 7 of ports C, D, E
		n.clk_choice = r.clksel; // RULE_16
		for (int p = 0; p < NP; p++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				n.pout[p][b] = r.out[p][b] ^ r.pctl[p][b][PCTL_INV];
				n.poe_n[p][b] = ~r.dir[p][b]; // RULE_22 RULE_15 RULE_19
			end
			if (r.event_output_port != 2'h0 && p == int'(r.event_output_port) + 1)
				n.pout[p][7] = event_ch0; // RULE_14
			n.p7clk[p] = r.clock_output_port != 2'h0 && p == int'(r.clock_output_port) + 1 && r.dir[p][7]; // RULE_17 RULE_18 RULE_19 RULE_20
		end
	end

	// state register
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			r <= '0;
			r.hready <= RST_HREADY;
			r.poe_n <= {(NP*8){RST_OE_N}};
		end
		else
			r <= n;
	end

	// outputs straight from state flops, except hresp tied to zero
	assign hreadyout = r.hready;
	assign hresp = 1'b0;
	assign hrdata = r.hrdata;
	assign pin_out = r.pout;
	assign pin_oe_n = r.poe_n;
	assign pin7_clk_sel = r.p7clk;
	assign output_clock_choice = r.clk_choice;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	AST_MASK_CLEAR: assert property ( // RULE_04
		w_go && w_dec.phy && w_dec.idx[4:3] == PHY_PCTL_HI |=> r.mask == 8'h00)
		else $error("mask not cleared after per-pin write");

	AST_BROADCAST: assert property ( // RULE_02
		w_go && w_dec.phy && w_dec.idx[4:3] == PHY_PCTL_HI && r.mask[2]
		|=> r.pctl[$past(w_port)][2][6:0] == $past(hwdata[6:0]))
		else $error("masked pin 2 missed group write");

	AST_ADDRESSED: assert property ( // RULE_03
		w_go && w_dec.phy && w_dec.idx[4:3] == PHY_PCTL_HI && r.mask == 8'h00
		|=> r.pctl[$past(w_port)][$past(w_pin)][6:0] == $past(hwdata[6:0]))
		else $error("addressed pin not written");

	AST_CLKEV_RSVD: assert property ( // RULE_13
		!r.hready && r_dec.cfg && r_dec.idx == CFG_CLKEV |=> r.hready && r.hrdata[7:6] == 2'h3)
		else $error("routing reserved bits not one");

	AST_FLAG_RSVD: assert property ( // RULE_12
		!r.hready && r_dec.phy && r_dec.idx == PHY_FLAGS |=> r.hrdata[7:2] == 6'h00)
		else $error("flag reserved bits not zero");

	AST_W0_KEEPS: assert property ( // RULE_11
		w_go && w_dec.phy && w_dec.idx == PHY_FLAGS && !hwdata[0] && r.flags[w_port][0]
		|=> r.flags[$past(w_port)][0])
		else $error("writing zero cleared a flag");

	AST_RISE_SETS: assert property ( // RULE_10
		$rose(r.lvl[2][1]) && $past(r.pctl[2][1][2:0]) == ISC_RISE && $past(r.im0[2][1])
		|-> r.flags[2][0])
		else $error("rising edge did not set flag");

	AST_CLK_PIN: assert property ( // RULE_19
		r.clock_output_port == 2'h1 && r.dir[2][7] |=> r.p7clk[2] ##1 r.clk_choice == $past(r.clksel))
		else $error("clock not routed to port c pin 7");

	AST_CLK_WINS: assert property ( // RULE_18
		r.clock_output_port == 2'h2 && r.event_output_port == 2'h2 && r.dir[3][7] |=> r.p7clk[3])
		else $error("clock did not override event");

	AST_EV_PIN: assert property ( // RULE_14
		r.event_output_port == 2'h1 |=> pin_out[2][7] == $past(event_ch0))
		else $error("event not routed to port c pin 7");

	AST_INPUT_OE: assert property ( // RULE_22
		!r.dir[3][0] |=> pin_oe_n[3][0])
		else $error("input pin driven");

	// configuration writes land as written
	AST_MASK_WRITE: assert property ( // RULE_01
		w_go && w_dec.cfg && w_dec.idx == CFG_MASK |=> r.mask == $past(hwdata[7:0]))
		else $error("group mask not stored");

	AST_VPA_WRITE: assert property ( // RULE_05
		w_go && w_dec.cfg && w_dec.idx == CFG_VPA
		|=> {r.vpmap[1], r.vpmap[0]} == $past(hwdata[7:0]))
		else $error("map a selectors not stored");

	AST_VPB_WRITE: assert property ( // RULE_06
		w_go && w_dec.cfg && w_dec.idx == CFG_VPB
		|=> {r.vpmap[3], r.vpmap[2]} == $past(hwdata[7:0]))
		else $error("map b selectors not stored");

	// virtual windows fold onto the selected physical port
	AST_VP_FOLD: assert property ( // RULE_07
		r.ap_valid && r.ap_addr[11:6] == 6'h04 && r.ap_addr[1:0] == 2'h0
		|-> w_dec.phy && w_dec.port == r.vpmap[r.ap_addr[5:4]])
		else $error("virtual window on wrong port");

	AST_VP_IDX: assert property ( // RULE_08
		r.ap_valid && r.ap_addr[11:6] == 6'h04 && r.ap_addr[3:0] == 4'h8
		|-> w_dec.idx == PHY_IN)
		else $error("virtual input not on input register");

	// input level follows the filtered pin
	AST_IN_LEVEL: assert property ( // RULE_09
		r.pctl[2][1][2:0] != ISC_OFF && !r.pctl[2][1][PCTL_INV]
		|=> r.lvl[2][1] == $past(r.filt[2][1]))
		else $error("input level not the filtered pin");

	AST_FLAG_CLEARS: assert property ( // RULE_11
		w_go && w_dec.phy && w_dec.idx == PHY_FLAGS && hwdata[1] && r.im1[w_port] == 8'h00
		|=> !r.flags[$past(w_port)][1])
		else $error("writing one left flag set");

	AST_RISE_ONLY: assert property ( // RULE_21
		$fell(r.lvl[2][1]) && $past(r.pctl[2][1][2:0]) == ISC_RISE
		&& $past(r.im0[2]) == 8'h02 && !$past(r.flags[2][0])
		|-> !r.flags[2][0])
		else $error("falling edge set a rise-only flag");

	// event and clock routing onto pin 7
	AST_EV_ROUTE: assert property ( // RULE_14
		r.event_output_port == 2'h2 |=> pin_out[3][7] == $past(event_ch0))
		else $error("event not routed to port d pin 7");

	AST_EV_GATED: assert property ( // RULE_15
		!r.dir[3][7] |=> pin_oe_n[3][7])
		else $error("event pin driven while input");

	AST_CLK_CHOICE: assert property ( // RULE_16
		r.clk_choice == $past(r.clksel))
		else $error("clock choice not forwarded");

	AST_CLK_OFF: assert property ( // RULE_17
		r.clock_output_port == 2'h0 |=> r.p7clk == '0)
		else $error("clock routed while disabled");

	AST_CLK_GATED: assert property ( // RULE_19
		!r.dir[4][7] |=> !r.p7clk[4])
		else $error("clock routed to input pin");

	AST_OUT_DRIVE: assert property ( // RULE_22
		r.dir[2][0] |=> !pin_oe_n[2][0])
		else $error("output pin not driven");

endmodule : pcv_top

// >>> pkg/pcv_pkg.sv
// shared constants and types for the port configuration and virtual port block
package pcv_pkg;

	// number of physical ports reachable through a 4-bit selector
	localparam int NP = 16;
	localparam int AW = 12;

	// address map: register index times four gives the byte address
	localparam logic [AW-1:0] CFG_BASE = 12'h000;
	localparam logic [AW-1:0] VP_BASE = 12'h100;
	localparam logic [AW-1:0] PHY_BASE = 12'h800;
	localparam int VP_STRIDE = 16;
	localparam int PHY_STRIDE = 128;

	// configuration register indices
	localparam logic [4:0] CFG_MASK = 5'h00;
	localparam logic [4:0] CFG_VPA = 5'h02;
	localparam logic [4:0] CFG_VPB = 5'h03;
	localparam logic [4:0] CFG_CLKEV = 5'h04;

	// virtual port register indices
	localparam logic [1:0] VP_DIR = 2'h0;
	localparam logic [1:0] VP_OUT = 2'h1;
	localparam logic [1:0] VP_IN = 2'h2;
	localparam logic [1:0] VP_FLAGS = 2'h3;

	// physical port register indices
	localparam logic [4:0] PHY_DIR = 5'h00;
	localparam logic [4:0] PHY_DIRSET = 5'h01;
	localparam logic [4:0] PHY_DIRCLR = 5'h02;
	localparam logic [4:0] PHY_DIRTGL = 5'h03;
	localparam logic [4:0] PHY_OUT = 5'h04;
	localparam logic [4:0] PHY_OUTSET = 5'h05;
	localparam logic [4:0] PHY_OUTCLR = 5'h06;
	localparam logic [4:0] PHY_OUTTGL = 5'h07;
	localparam logic [4:0] PHY_IN = 5'h08;
	localparam logic [4:0] PHY_IM0 = 5'h0a;
	localparam logic [4:0] PHY_IM1 = 5'h0b;
	localparam logic [4:0] PHY_FLAGS = 5'h0c;
	localparam logic [1:0] PHY_PCTL_HI = 2'h2;

	// field layout of a per-pin control byte
	localparam int PCTL_INV = 6;
	localparam logic [2:0] ISC_BOTH = 3'h0;
	localparam logic [2:0] ISC_RISE = 3'h1;
	localparam logic [2:0] ISC_FALL = 3'h2;
	localparam logic [2:0] ISC_LOW = 3'h3;
	localparam logic [2:0] ISC_OFF = 3'h7;

	// fixed read values and reset values
	localparam logic [1:0] CLKEV_RSVD = 2'h3;
	localparam logic [5:0] FLAGS_RSVD = 6'h00;
	localparam logic RST_HREADY = 1'b1;
	localparam logic RST_OE_N = 1'b1;

	// decoded target of a bus address
	typedef struct packed {
		logic cfg;
		logic phy;
		logic [3:0] port;
		logic [4:0] idx;
	} pcv_dec_s;

	// complete block state
	typedef struct packed {
		logic [NP-1:0][7:0] sy1;
		logic [NP-1:0][7:0] sy2;
		logic [NP-1:0][7:0] sy3;
		logic [NP-1:0][7:0] filt;
		logic [NP-1:0][7:0] lvl;
		logic [NP-1:0][7:0] dir;
		logic [NP-1:0][7:0] out;
		logic [NP-1:0][7:0] im0;
		logic [NP-1:0][7:0] im1;
		logic [NP-1:0][1:0] flags;
		logic [NP-1:0][7:0][7:0] pctl;
		logic [7:0] mask;
		logic [3:0][3:0] vpmap;
		logic [1:0] event_output_port;
		logic [1:0] clksel;
		logic [1:0] clock_output_port;
		logic ap_valid;
		logic ap_write;
		logic [AW-1:0] ap_addr;
		logic hready;
		logic [31:0] hrdata;
		logic [NP-1:0][7:0] pout;
		logic [NP-1:0][7:0] poe_n;
		logic [NP-1:0] p7clk;
		logic [1:0] clk_choice;
	} pcv_state_s;

endpackage : pcv_pkg

// >>> testbench/pcv_pad_model.sv
// pad ring model that feeds pin levels back to the block
`timescale 1ns/10ps
module pcv_pad_model
	import pcv_pkg::*;
(
	// device side
	input wire logic [NP-1:0][7:0] pin_out,
	input wire logic [NP-1:0][7:0] pin_oe_n,
	// board side
	input wire logic [NP-1:0][7:0] ext_level,
	output logic [NP-1:0][7:0] pin_in
);
	// a driven pin reads its own level, an undriven one the board level
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : pcv_pad_model

// >>> testbench/tb.sv
// self-checking bench for port configuration and virtual ports
`timescale 1ns/10ps
module tb;
	import pcv_pkg::*;
	logic mclk = 0, reset = 1, hsel = 0, hwrite = 0, event_ch0 = 0, hreadyout, hresp, ok;
	logic [1:0] htrans = 2'h0, output_clock_choice;
	logic [AW-1:0] haddr = '0;
	logic [31:0] hwdata = '0, hrdata, rd;
	logic [NP-1:0][7:0] pin_in, pin_out, pin_oe_n, ext_level = '0;
	logic [NP-1:0] pin7_clk_sel;
	int n_mismatch = 0, comparisons = 0;

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	pcv_top DUT (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .event_ch0(event_ch0),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin7_clk_sel(pin7_clk_sel),
		.output_clock_choice(output_clock_choice));
	pcv_pad_model pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
		.pin_in(pin_in));

	task stop_test;
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// waits for hready sampled high at a falling edge, capturing read data there, then steps to the next rising edge
	task wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(negedge mclk);
			ok = hreadyout;
			rd = hrdata;
			@(posedge mclk);
			n++;
		end while (ok !== 1'b1 && n < 50);
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			stop_test();
		end
	endtask : wait_rdy

	// one single ahb transfer, address phase then data phase
	task xfer(input logic w, input logic [AW-1:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy();
	endtask : xfer

	task rd_chk(input logic [AW-1:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk(rd, {24'h0, e});
	endtask : rd_chk

	task settle;
		repeat (3) @(negedge mclk);
	endtask : settle

	function automatic logic [AW-1:0] ca(input int i);
		return CFG_BASE + AW'(i * 4);
	endfunction : ca

	function automatic logic [AW-1:0] va(input int v, input int i);
		return VP_BASE + AW'(v * VP_STRIDE + i * 4);
	endfunction : va

	function automatic logic [AW-1:0] pa(input int p, input int i);
		return PHY_BASE + AW'(p * PHY_STRIDE + i * 4);
	endfunction : pa

	// group write to pins 2,3 through pin 0, then mask cleared
	task sc_mask;
		xfer(1'b1, ca(CFG_MASK), 8'h0c);
		xfer(1'b1, pa(0, 16), 8'h41);
		rd_chk(ca(CFG_MASK), 8'h00);
		rd_chk(pa(0, 16), 8'h41);
		rd_chk(pa(0, 18), 8'h41);
		rd_chk(pa(0, 19), 8'h41);
		rd_chk(pa(0, 17), 8'h00);
		xfer(1'b1, pa(0, 17), 8'h02);
		rd_chk(pa(0, 18), 8'h41);
	endtask : sc_mask

	// virtual windows onto ports C, F, D and P
	task sc_vport;
		xfer(1'b1, ca(CFG_VPA), 8'h52);
		xfer(1'b1, ca(CFG_VPB), 8'hf3);
		xfer(1'b1, va(0, VP_DIR), 8'ha5);
		rd_chk(pa(2, PHY_DIR), 8'ha5);
		xfer(1'b1, pa(5, PHY_DIR), 8'h11);
		rd_chk(va(1, VP_DIR), 8'h11);
		xfer(1'b1, pa(15, PHY_OUT), 8'h3c);
		rd_chk(va(3, VP_OUT), 8'h3c);
		xfer(1'b1, va(2, VP_OUT), 8'h00);
		rd_chk(ca(1), 8'h00);
		settle();
		chk(pin_oe_n[2], 8'h5a);
		@(posedge mclk);
	endtask : sc_vport

	// input level and flags through virtual port 0
	task sc_input;
		xfer(1'b1, pa(2, PHY_IM0), 8'h02);
		xfer(1'b1, pa(2, 17), 8'h01);
		ext_level[2] <= 8'h02;
		repeat (6) @(posedge mclk);
		rd_chk(va(0, VP_IN), 8'h02);
		rd_chk(va(0, VP_FLAGS), 8'h01);
		xfer(1'b1, va(0, VP_FLAGS), 8'h02);
		rd_chk(va(0, VP_FLAGS), 8'h01);
		xfer(1'b1, va(0, VP_FLAGS), 8'h01);
		rd_chk(pa(2, PHY_FLAGS), 8'h00);
		ext_level[2] <= 8'h00;
		repeat (6) @(posedge mclk);
		rd_chk(va(0, VP_FLAGS), 8'h00);
	endtask : sc_input

	// event and clock routing to pin 7 of C, D, E
	task sc_route;
		xfer(1'b1, ca(CFG_CLKEV), 8'h25);
		rd_chk(ca(CFG_CLKEV), 8'he5);
		event_ch0 <= 1'b1;
		settle();
		chk(pin_oe_n[3][7], 1'b1);
		@(posedge mclk);
		xfer(1'b1, pa(3, PHY_DIRSET), 8'h80);
		xfer(1'b1, pa(4, PHY_DIRSET), 8'h80);
		for (int i = 1; i < 4; i++)
		begin
			xfer(1'b1, ca(CFG_CLKEV), 8'(i << 4));
			settle();
			chk(pin_out[i + 1][7], 1'b1);
			@(posedge mclk);
		end
		event_ch0 <= 1'b0;
		settle();
		chk(pin_out[4][7], 1'b0);
		@(posedge mclk);
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b1, ca(CFG_CLKEV), 8'((i % 3) << 2 | i));
			settle();
			chk(pin7_clk_sel, (i == 0) ? 16'h0 : 16'h1 << (i + 1));
			chk(output_clock_choice, i % 3);
			@(posedge mclk);
		end
		xfer(1'b1, ca(CFG_CLKEV), 8'h2a);
		settle();
		chk(pin7_clk_sel, 16'h0008);
		@(posedge mclk);
		xfer(1'b1, pa(3, PHY_DIRCLR), 8'h80);
		settle();
		chk(pin7_clk_sel, 16'h0);
		chk(hresp, 1'b0);
		chk(hreadyout, 1'b1);
		@(posedge mclk);
	endtask : sc_route

	// main sequence
	initial
	begin
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		sc_mask();
		sc_vport();
		sc_input();
		sc_route();
		stop_test();
	end
endmodule : tb
